// >>> hdl/emb_params.svh
// Constants for the external memory bus pin block.
// Assumes inclusion by bare name from design files under hdl/.
`ifndef EMB_PARAMS_SVH
`define EMB_PARAMS_SVH
`define EMB_BUS_WIDTH 24
`define EMB_LOW_ADDR_WIDTH 3
`define EMB_GP_LINES 6
`define EMB_BANKS 8
`define EMB_ALE_CYCLES 1
`define EMB_CAS_GP_INDEX 3
`define EMB_WAIT_GP_INDEX 4
`define EMB_BURST_MAX 8
`define EMB_PATTERN_DEPTH 16
`endif

// >>> hdl/emb_pkg.sv
// Types shared by the external memory bus pin block.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package emb_pkg;
  typedef enum logic [1:0] {
    EMB_MACH_NONE,
    EMB_MACH_CHIPSEL,
    EMB_MACH_SDRAM,
    EMB_MACH_PATTERN
  } emb_machine_t;
endpackage : emb_pkg
`default_nettype wire

// >>> hdl/emb_bank_if.sv
// Bank select passed from the access sequencer to the bank decoder; decoded bank options passed back.
// Assumes one clock domain; carries plain levels.
`default_nettype none
interface emb_bank_if;
  logic [2:0] bankSel;
  emb_pkg::emb_machine_t machine;
  logic bufCtrlDisable;
  modport seq (output bankSel, input machine, input bufCtrlDisable);
  modport dec (input bankSel, output machine, output bufCtrlDisable);
endinterface : emb_bank_if
`default_nettype wire

// >>> hdl/emb_bank_decode.sv
// Decodes per-bank machine type and buffer-control-disable bit.
// Assumes the option levels arrive as flat vectors, stable between accesses.
`default_nettype none
`include "emb_params.svh"
module emb_bank_decode #(
  parameter int BANKS = `EMB_BANKS
) (
  // Option table
  input wire logic [2*BANKS-1:0] bankMachine,
  input wire logic [BANKS-1:0] bankBufCtrlDisable,
  // Sequencer side
  emb_bank_if.dec bank
);
  wire logic [1:0] selMachine;
  assign selMachine = bankMachine[bank.bankSel*2 +: 2];
  assign bank.machine = emb_pkg::emb_machine_t'(selMachine);
  assign bank.bufCtrlDisable = bankBufCtrlDisable[bank.bankSel];
endmodule : emb_bank_decode
`default_nettype wire

// >>> hdl/emb_pin_ctrl.sv
// External memory bus pin controller: muxed address/data bus, latch strobe,
// low address pins, buffer direction control and shared strobe pins.
// Assumes pins are synchronous to ref_clk and all option inputs are static
// during an access.
//
// Overview of operation
// - SDRAM banks: shared strobe pin acts as SDRAM column strobe.
// - Pattern mode: six general lines driven each cycle from pattern array.
// - Chip-select banks: termination pin is input that ends the access.
// - Pattern mode: termination pin may be wait input stalling the sequencer.
// - Buffer control active only for chip-select or pattern banks, never SDRAM.
// - Buffer control suppressed when the bank's disable bit is set.
// - Buffer control is the transceiver write/read direction.
// - Buffer control high after reset and in every address phase.
// - Low address bits always shown on dedicated unlatched pins.
// - Low address pins step per beat during burst accesses.
// - Addresses and data share one 24-bit bidirectional bus.
// - Shared bus carries the address while the latch strobe is asserted.
// - After the strobe, bus drives write data or floats to sample reads.
// - Shared bus floats right after the final write data transfer.
`default_nettype none
`include "emb_params.svh"
module emb_pin_ctrl #(
  parameter int WIDTH = `EMB_BUS_WIDTH,
  parameter int BANKS = `EMB_BANKS,
  parameter int DEPTH = `EMB_PATTERN_DEPTH
) (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst,
  // Access request from the internal bus
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [2:0] reqBank,
  input wire logic [WIDTH-1:0] reqAddr,
  input wire logic [WIDTH-1:0] reqWdata,
  input wire logic [3:0] reqBeats,
  input wire logic waitEnable,
  output logic reqReady,
  output logic doneStrobe,
  output logic [WIDTH-1:0] readData,
  // Bank options
  input wire logic [2*BANKS-1:0] bankMachine,
  input wire logic [BANKS-1:0] bankBufCtrlDisable,
  input wire logic [DEPTH*`EMB_GP_LINES-1:0] patternArray,
  // Multiplexed address/data bus
  input wire logic [WIDTH-1:0] muxedAddrDataIn,
  output logic [WIDTH-1:0] muxedAddrDataOut,
  output logic muxedAddrDataOe,
  output logic addrLatchStrobe,
  output logic [`EMB_LOW_ADDR_WIDTH-1:0] lowAddrPins,
  output logic bufferDirCtrlPin,
  // Shared strobe pins
  output logic [`EMB_GP_LINES-1:0] gpLines,
  output logic sdramColStrobePin,
  input wire logic transferAckIn,
  output logic transferAckOe
);
  // ----------------------------------------------------------------------
  // Bank decode
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_ADDR, ST_DATA} emb_state_t;
  emb_state_t state, next_state;
  emb_bank_if bank ();
  emb_bank_decode #(.BANKS(BANKS)) u_dec (
    .bankMachine(bankMachine),
    .bankBufCtrlDisable(bankBufCtrlDisable),
    .bank(bank)
  );
  logic [2:0] curBank;
  logic curWrite;
  logic [WIDTH-1:0] curAddr;
  logic [3:0] beatsLeft;
  logic [3:0] patIdx;
  logic curWaitEn;
  assign bank.bankSel = curBank;

  // ----------------------------------------------------------------------
  // Decodes
  // ----------------------------------------------------------------------
  wire logic isSdram = (bank.machine == emb_pkg::EMB_MACH_SDRAM);
  wire logic isPattern = (bank.machine == emb_pkg::EMB_MACH_PATTERN);
  wire logic isChipSel = (bank.machine == emb_pkg::EMB_MACH_CHIPSEL);
  // Buffer control may move only for chip-select or pattern banks.
  wire logic bufAllowed = (isChipSel | isPattern) & ~bank.bufCtrlDisable;
  // Termination pin: ack for chip-select, wait for pattern when enabled.
  wire logic ackSeen = isChipSel & transferAckIn;
  wire logic waitSeen = isPattern & curWaitEn & transferAckIn;
  wire logic pinIsInput = isChipSel | (isPattern & curWaitEn);
  wire logic lastBeat = (beatsLeft == 4'h0);
  wire logic beatDone = isChipSel ? ackSeen : ~waitSeen;
  wire logic finishing = (state == ST_DATA) & beatDone & lastBeat;
  wire logic [`EMB_GP_LINES-1:0] patWord = patternArray[patIdx*`EMB_GP_LINES +: `EMB_GP_LINES];
  // The low pins must show the beat now on the bus, so they follow the
  // stepped address instead of lagging one beat behind it.
  wire logic stepAddr = (state == ST_DATA) & beatDone & ~lastBeat;
  wire logic [WIDTH-1:0] nextAddr = curAddr + WIDTH'(1);
  wire logic [2:0] nextLow = stepAddr ? nextAddr[2:0] : curAddr[2:0];

  always_comb begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (reqValid) begin
          next_state = ST_ADDR;
        end
      end
      ST_ADDR: begin
        next_state = ST_DATA;
      end
      ST_DATA: begin
        if (finishing) begin
          next_state = ST_IDLE;
        end
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // ----------------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------------
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state <= ST_IDLE;
      curBank <= 3'h0;
      curWrite <= 1'b0;
      curAddr <= '0;
      beatsLeft <= 4'h0;
      patIdx <= 4'h0;
      curWaitEn <= 1'b0;
    end else begin
      state <= next_state;
      // Bank and mode are captured only when idle, so pin roles never
      // change in the middle of an access.
      if (state == ST_IDLE && reqValid) begin
        curBank <= reqBank;
        curWrite <= reqWrite;
        curAddr <= reqAddr;
        beatsLeft <= reqBeats;
        curWaitEn <= waitEnable;
        patIdx <= 4'h0;
      end else if (state == ST_DATA && beatDone && !lastBeat) begin
        beatsLeft <= beatsLeft - 4'h1;
        curAddr <= nextAddr;
      end
      if (state != ST_IDLE && isPattern && !waitSeen) begin
        patIdx <= patIdx + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Pin drivers
  // ----------------------------------------------------------------------
  wire logic addrPhase = (next_state == ST_ADDR);
  wire logic dataNext = (next_state == ST_DATA);
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      addrLatchStrobe <= 1'b0;
      muxedAddrDataOut <= '0;
      muxedAddrDataOe <= 1'b0;
      lowAddrPins <= '0;
      bufferDirCtrlPin <= 1'b1;
      gpLines <= '0;
      sdramColStrobePin <= 1'b1;
      transferAckOe <= 1'b0;
      reqReady <= 1'b0;
      doneStrobe <= 1'b0;
      readData <= '0;
    end else begin
      addrLatchStrobe <= addrPhase;
      // Address while strobe high, then write data or float for reads.
      muxedAddrDataOut <= addrPhase ? reqAddr : reqWdata;
      muxedAddrDataOe <= addrPhase | (dataNext & curWrite & ~finishing);
      lowAddrPins <= addrPhase ? reqAddr[2:0] : nextLow;
      // High from reset and through address phase; low only for reads on
      // buffered banks so the transceiver drives toward the controller.
      bufferDirCtrlPin <= addrPhase | ~dataNext | curWrite | ~bufAllowed;
      gpLines <= isPattern && state != ST_IDLE ? patWord : '0;
      sdramColStrobePin <= ~(isSdram && state == ST_DATA);
      transferAckOe <= isPattern & ~pinIsInput;
      reqReady <= (next_state == ST_IDLE) & ~reqValid;
      doneStrobe <= finishing;
      if (state == ST_DATA && beatDone && !curWrite) begin
        readData <= muxedAddrDataIn;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence ale_then_data;
    addrLatchStrobe ##1 !addrLatchStrobe;
  endsequence
  buffer_control_addr_high_a: assert property (@(posedge ref_clk) disable iff (rst)
    addrLatchStrobe |-> bufferDirCtrlPin) else $error("buffer control low in address phase");
  buffer_control_sdram_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_DATA && isSdram) |=> bufferDirCtrlPin) else $error("buffer control moved on SDRAM");
  buffer_control_disable_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_DATA && bank.bufCtrlDisable) |=> bufferDirCtrlPin)
    else $error("buffer control moved while disabled");
  ale_drives_bus_a: assert property (@(posedge ref_clk) disable iff (rst)
    addrLatchStrobe |-> muxedAddrDataOe) else $error("bus not driven during address strobe");
  read_floats_a: assert property (@(posedge ref_clk) disable iff (rst)
    ale_then_data ##0 !curWrite |-> !muxedAddrDataOe) else $error("bus driven on read data");
  write_release_a: assert property (@(posedge ref_clk) disable iff (rst)
    doneStrobe |-> !muxedAddrDataOe) else $error("bus held after final write");
  cas_sdram_a: assert property (@(posedge ref_clk) disable iff (rst)
    !sdramColStrobePin |-> $past(isSdram)) else $error("column strobe outside SDRAM");
  wait_holds_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state == ST_DATA && waitSeen) |=> $stable(patIdx)) else $error("pattern advanced in wait");
  bank_stable_a: assert property (@(posedge ref_clk) disable iff (rst)
    (state != ST_IDLE) |=> (state == ST_IDLE) || $stable(curBank)) else $error("bank changed");
  low_addr_track_a: assert property (@(posedge ref_clk) disable iff (rst)
    lowAddrPins == curAddr[2:0]) else $error("low address pins lag the beat address");
endmodule : emb_pin_ctrl
`default_nettype wire

// >>> tb/emb_far_model.sv
// Far side of the bus: address latch, memory and transceiver.
// Assumes controller pins on ref_clk; the bench picks the acknowledge delay.
`default_nettype none
module emb_far_model (
  // Clock
  input wire logic ref_clk,
  // Controller pins
  input wire logic [23:0] busOut,
  input wire logic busOe,
  input wire logic ale,
  input wire logic [2:0] lowAddr,
  input wire logic bufDir,
  // Bench controls
  input wire logic directRead,
  input wire logic waitHold,
  input wire logic [3:0] ackDelay,
  // Far side drive
  output logic [23:0] busIn,
  output logic termDrive
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [23:0] latched;
  logic [23:0] lastDrv = 24'h00_0000;
  logic [3:0] cnt = 4'h0;
  logic drive;
  // Released lines show the inverse of the last value so stale data never matches.
  assign drive = !busOe && !ale && (!bufDir || directRead);
  always_ff @(posedge ref_clk) begin
    if (ale) latched <= busOut;
    cnt <= ale ? 4'h0 : cnt + {3'h0, cnt != 4'hf};
    if (drive) lastDrv <= busIn;
  end
  assign busIn = drive ? ({latched[23:3], lowAddr} ^ 24'h5A_5A5A) : ~lastDrv;
  // A delay of all ones means the device never terminates on its own.
  assign termDrive = waitHold || (ackDelay != 4'hf && cnt >= ackDelay && !ale);
endmodule : emb_far_model
`default_nettype wire

// >>> tb/test_ext_mem_bus_pin_interface.sv
// Self-checking bench for the external memory bus pin controller.
// Assumes emb_pin_ctrl with default parameters and the far side model.
`default_nettype none
`include "emb_params.svh"
module test_ext_mem_bus_pin_interface;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk = 0, rst = 1, reqValid = 0, reqWrite = 0, waitEnable = 0;
  logic [2:0] reqBank = 0;
  logic [23:0] reqAddr = 0, reqWdata = 0;
  logic [3:0] reqBeats = 0, ackDelay = 4'hf;
  logic directRead = 0, waitHold = 0;
  logic reqReady, doneStrobe, oe, ale, dir, cas, ackOe, term;
  logic [23:0] readData, busOut, busIn;
  logic [2:0] lowAddr;
  logic [5:0] gp;
  logic mDir, mCas, mOe, mGp;
  logic [2:0] mLow;
  logic farTerm;
  // Distinct words, so that a stuck or skipped pattern index shows on the lines.
  logic [95:0] patArr = {6'h2F, 6'h2E, 6'h2D, 6'h2C, 6'h2B, 6'h2A, 6'h29, 6'h28,
    6'h27, 6'h26, 6'h25, 6'h24, 6'h23, 6'h22, 6'h21, 6'h20};
  int error_cnt = 0, n_compared = 0, mCyc;
  always #2.5 ref_clk = ~ref_clk;
  emb_pin_ctrl dut (.ref_clk(ref_clk), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
    .reqBank(reqBank), .reqAddr(reqAddr), .reqWdata(reqWdata), .reqBeats(reqBeats),
    .waitEnable(waitEnable), .reqReady(reqReady), .doneStrobe(doneStrobe),
    .readData(readData), .bankMachine(16'h00F9), .bankBufCtrlDisable(8'h08),
    .patternArray(patArr), .muxedAddrDataIn(busIn), .muxedAddrDataOut(busOut),
    .muxedAddrDataOe(oe), .addrLatchStrobe(ale), .lowAddrPins(lowAddr),
    .bufferDirCtrlPin(dir), .gpLines(gp), .sdramColStrobePin(cas),
    .transferAckIn(term), .transferAckOe(ackOe));
  emb_far_model far (.ref_clk(ref_clk), .busOut(busOut), .busOe(oe), .ale(ale),
    .lowAddr(lowAddr), .bufDir(dir), .directRead(directRead), .waitHold(waitHold),
    .ackDelay(ackDelay), .busIn(busIn), .termDrive(farTerm));
  assign term = ackOe ? gp[`EMB_WAIT_GP_INDEX] : farTerm;
  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic check(input string nm, input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : check
  task automatic acc(input logic [2:0] b, input logic w, input logic [23:0] a,
                     input logic [3:0] n, input logic we);
    int k;
    logic [5:0] expGp;
    mDir = 1;
    mCas = 0;
    mOe = 0;
    mGp = 0;
    mCyc = 0;
    mLow = 0;
    k = 0;
    while (reqReady !== 1'b1 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    check("ready", reqReady, 1);
    @(posedge ref_clk);
    reqValid <= 1;
    reqWrite <= w;
    reqBank <= b;
    reqAddr <= a;
    reqWdata <= ~a;
    reqBeats <= n;
    waitEnable <= we;
    for (k = 0; k < 80; k++) begin
      @(posedge ref_clk);
      reqValid <= 0;
      #1;
      mCyc++;
      if (doneStrobe === 1'b1) break;
      // Banks 2 and 3 are pattern banks; word k-2 shows after the k-th edge.
      expGp = (b >= 3'h2) ? {2'b10, 4'(mCyc - 2)} : 6'h00;
      if (ale === 1'b1) begin
        check("addr", busOut, a);
        check("addr oe", oe, 1);
        check("low addr", lowAddr, a[2:0]);
        check("dir addr", dir, 1);
      end else begin
        mDir &= dir;
        mCas |= !cas;
        mOe |= oe;
        mLow = lowAddr;
        if (w) check("wr data", busOut, ~a);
        if (!(we && b >= 3'h2) && gp !== expGp) mGp = 1;
      end
    end
    check("done", doneStrobe, 1);
    check("oe done", oe, 0);
  endtask : acc
  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_cs_write;
    ackDelay = 2;
    acc(0, 1, 24'h12_3450, 3, 0);
    check("cs wr dir", mDir, 1);
    check("cs wr oe", mOe, 1);
    check("cs wr low", mLow, 3'h3);
  endtask : t_cs_write
  task automatic t_cs_read;
    ackDelay = 5;
    acc(0, 0, 24'hAB_CDE5, 0, 0);
    check("cs rd dir", mDir, 0);
    check("cs rd oe", mOe, 0);
    check("cs rd data", readData, 24'hAB_CDE5 ^ 24'h5A_5A5A);
    // Acknowledge rises five cycles after the strobe falls; done follows it.
    check("cs slow", 24'(mCyc), 24'h00_0008);
  endtask : t_cs_read
  task automatic t_sdram_read;
    directRead = 1;
    acc(1, 0, 24'h00_1230, 2, 0);
    check("sd dir", mDir, 1);
    check("sd cas", mCas, 1);
    check("sd lines", mGp, 0);
    check("sd data", readData, 24'h00_1232 ^ 24'h5A_5A5A);
  endtask : t_sdram_read
  task automatic t_pat_off;
    acc(3, 0, 24'h00_0040, 1, 0);
    check("pat dir off", mDir, 1);
    check("pat lines", mGp, 0);
    directRead = 0;
  endtask : t_pat_off
  task automatic t_pat_wait;
    // Only the wait input may end the stall, so the model never acknowledges.
    ackDelay = 4'hf;
    waitHold = 1;
    fork
      acc(2, 0, 24'h00_0080, 0, 1);
      begin
        repeat (20) @(posedge ref_clk);
        waitHold <= 0;
      end
    join
    check("pat stall", 24'(mCyc), 24'h00_0014);
    check("pat dir", mDir, 0);
  endtask : t_pat_wait
  task automatic tally_and_finish;
    $display("Compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (5) @(posedge ref_clk);
    #1;
    check("rst dir", dir, 1);
    check("rst cas", cas, 1);
    check("rst ale", ale, 0);
    @(posedge ref_clk);
    rst <= 0;
    t_cs_write();
    t_cs_read();
    t_sdram_read();
    t_pat_off();
    t_pat_wait();
    tally_and_finish();
  end
  initial begin
    #5000;
    error_cnt++;
    tally_and_finish();
  end
endmodule : test_ext_mem_bus_pin_interface
`default_nettype wire
